// [design/wut_pkg.sv]
// shared constants and types for the wake-up timer
package wut_pkg;

  // ***************************************************
  // register addresses
  // ***************************************************
  localparam logic [10:0] ADDR_CFG_A   = 11'h316;
  localparam logic [10:0] ADDR_CFG_B   = 11'h317;
  localparam logic [10:0] ADDR_CTRL    = 11'h318;
  localparam logic [10:0] ADDR_RLD_LO  = 11'h319;
  localparam logic [10:0] ADDR_RLD_HI  = 11'h31a;
  localparam logic [10:0] ADDR_INT_A   = 11'h31b;
  localparam logic [10:0] ADDR_INT_B   = 11'h31c;
  localparam logic [10:0] ADDR_STATUS  = 11'h31d;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int PRESC_LSB         = 0;
  localparam int PRESC_W           = 3;
  localparam int SLEEP_SEL_LSB     = 3;
  localparam int SLEEP_SEL_W       = 4;
  localparam int ARM_BIT           = 7;
  localparam int CTRL_FLAG_RST_BIT = 0;
  localparam int CTRL_CAL_BIT      = 1;
  localparam int CTRL_CLK_EN_BIT   = 2;
  localparam int INT_TIMEOUT_BIT   = 0;
  localparam int STAT_FLAG_BIT     = 0;
  localparam int STAT_CAL_BIT      = 1;
  localparam int STAT_SLEEP_BIT    = 2;
  localparam int STAT_CAL_BUSY_BIT = 3;

  // ***************************************************
  // reset values and codes
  // ***************************************************
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [3:0]  SLEEP_SEL_XTAL = 4'h1;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int SLOW_CLK_HZ  = 32768;
  localparam int CLK_FREQ_MHZ = 200;
  localparam int CAL_TIME_MS  = 1;
  localparam int CAL_CYCLES   = CAL_TIME_MS * CLK_FREQ_MHZ * 1000;
  localparam int CAL_CNT_W    = 18;

  // ***************************************************
  // types
  // ***************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [10:0] addr;
    logic [7:0]  data;
  } wut_regreq_t;

  typedef struct packed {
    logic [7:0]           cfgA;
    logic [7:0]           cfgB;
    logic [7:0]           ctrl;
    logic [7:0]           rldLo;
    logic [7:0]           rldHi;
    logic [7:0]           intA;
    logic [7:0]           intB;
    logic [15:0]          count;
    logic                 running;
    logic                 flag;
    logic                 irqA;
    logic                 irqB;
    logic                 sleep;
    logic                 wakeUp;
    logic                 calBusy;
    logic                 calDone;
    logic [CAL_CNT_W-1:0] calCnt;
    logic [7:0]           rdData;
    logic                 rdValid;
  } wut_state_t;

endpackage

// [design/wut_pin_sync.sv]
// three-stage pin synchroniser with rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module wut_pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] riseEdge
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } wut_sync_t;

  wut_sync_t syncReg;
  wut_sync_t syncNext;

  if (WIDTH < 1) begin : gWidthCheck
    $error("pin sync width must be at least one");
  end

  always_comb begin
    syncNext    = syncReg;
    syncNext.s1 = pinIn;
    syncNext.s2 = syncReg.s1;
    syncNext.s3 = syncReg.s2;
    // agreed level only moves when stages two and three match
    syncNext.lvl = (syncReg.s2 & syncReg.s3) | (syncReg.lvl & (syncReg.s2 | syncReg.s3));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      syncReg <= '0;
    end else begin
      syncReg <= syncNext;
    end
  end

  // first stage feeds only the second; edge needs stages two and three to agree
  for (genvar i = 0; i < WIDTH; i++) begin : gEdge
    assign riseEdge[i] = syncReg.s2[i] & syncReg.s3[i] & ~syncReg.lvl[i];
  end

endmodule
`default_nettype wire

// [design/wut_prescaler.sv]
// programmable tick divider for the slow clock
`timescale 1ns/1ps
`default_nettype none
module wut_prescaler
  import wut_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               enable,
  input  wire logic               slowEdge,
  input  wire logic [PRESC_W-1:0] divSel,
  output logic                    tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } wut_presc_t;

  wut_presc_t presReg;
  wut_presc_t presNext;

  function automatic logic [15:0] divTerminal(input logic [PRESC_W-1:0] sel);
    case (sel)
      3'h0:    divTerminal = 16'h0000;
      3'h1:    divTerminal = 16'h0003;
      3'h2:    divTerminal = 16'h0007;
      3'h3:    divTerminal = 16'h000f;
      3'h4:    divTerminal = 16'h007f;
      3'h5:    divTerminal = 16'h03ff;
      3'h6:    divTerminal = 16'h1fff;
      default: divTerminal = 16'hffff;
    endcase
  endfunction

  always_comb begin
    presNext      = presReg;
    presNext.tick = 1'b0;
    if (!enable) begin
      presNext.cnt = 16'h0000;
    end else if (slowEdge) begin
      // >= so a smaller divider written mid-count cannot run past its end
      if (presReg.cnt >= divTerminal(divSel)) begin
        presNext.cnt  = 16'h0000;
        presNext.tick = 1'b1;
      end else begin
        presNext.cnt = presReg.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      presReg <= '0;
    end else begin
      presReg <= presNext;
    end
  end

  assign tick = presReg.tick;

endmodule
`default_nettype wire

// [design/wut_wake_timer.sv]
// wake-up timer: registers, down counter, flag, sleep exit, rc calibration
//
// Operation
// - tick source is a 32.768 kHz clock
// - config b bits 6:3 pick crystal or rc
// - 3-bit prescaler clocks a 16-bit down counter
// - prescaler codes divide 1 to 65536
// - enable loads reload, then decrements per tick
// - interrupt raised when counter reaches zero
// - either interrupt line may carry the timeout
// - armed timeout wakes device from sleep
// - rc calibrates only on 0 then 1
// - calibration ends after 1 ms, sets flag
`timescale 1ns/1ps
`default_nettype none
module wut_wake_timer
  import wut_pkg::*;
#(
  parameter int CAL_TICKS = CAL_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire wut_regreq_t regReq,
  output logic [7:0]       rdData,
  output logic             rdValid,
  input  wire logic        rcOscPin,
  input  wire logic        xtalPin,
  input  wire logic        sleepCmd,
  output logic             irqLineA,
  output logic             irqLineB,
  output logic             sleepState,
  output logic             wakeUp,
  output logic             rcCalActive
);

  // ***************************************************
  // elaboration checks
  // ***************************************************
  if (CAL_TICKS < 1 || CAL_TICKS > (2 ** CAL_CNT_W) - 1) begin : gCalCheck
    $error("calibration count does not fit its counter");
  end
  if (CAL_CNT_W < 1 || CAL_CNT_W > 31) begin : gCalWidthCheck
    $error("calibration counter width out of range");
  end
  if (SLOW_CLK_HZ != 32768) begin : gSlowCheck
    $error("slow source must run at 32.768 kHz");
  end
  // each slow level must last several clocks or the synchroniser drops edges
  if (CLK_FREQ_MHZ * 1000000 < 8 * SLOW_CLK_HZ) begin : gRateCheck
    $error("system clock too slow to sample the slow source");
  end
  if (PRESC_W != 3 || PRESC_LSB + PRESC_W > 8) begin : gCfgACheck
    $error("tick divider select does not fit its field");
  end
  if (SLEEP_SEL_LSB + SLEEP_SEL_W > ARM_BIT || ARM_BIT > 7) begin : gCfgBCheck
    $error("clock select field and arm bit collide");
  end
  if (CTRL_FLAG_RST_BIT > 7 || CTRL_CAL_BIT > 7 || CTRL_CLK_EN_BIT > 7) begin : gCtrlRange
    $error("control field outside its register");
  end
  if (CTRL_FLAG_RST_BIT == CTRL_CAL_BIT || CTRL_CAL_BIT == CTRL_CLK_EN_BIT
      || CTRL_FLAG_RST_BIT == CTRL_CLK_EN_BIT) begin : gCtrlCheck
    $error("control fields share a bit");
  end
  if (STAT_FLAG_BIT > 7 || STAT_CAL_BIT > 7 || STAT_SLEEP_BIT > 7
      || STAT_CAL_BUSY_BIT > 7) begin : gStatCheck
    $error("status field outside its register");
  end
  if (INT_TIMEOUT_BIT > 7) begin : gIntCheck
    $error("timeout enable bit outside its register");
  end
  if (ADDR_STATUS - ADDR_CFG_A != 11'h007) begin : gMapCheck
    $error("register block is not contiguous");
  end

  // ***************************************************
  // state and local signals
  // ***************************************************
  wut_state_t stateReg;
  wut_state_t stateNext;

  logic [1:0]  pinEdge;
  logic        slowEdge;
  logic        selXtal;
  logic        tick;
  logic        expiry;
  logic        calStart;
  logic [15:0] reloadVal;
  logic        clkEnable;
  logic        clearHeld;
  logic        armed;

  // ***************************************************
  // slow clock pins and source select
  // ***************************************************
  wut_pin_sync #(
    .WIDTH (2)
  ) uPinSync (
    .clk      (clk),
    .rst      (rst),
    .pinIn    ({xtalPin, rcOscPin}),
    .riseEdge (pinEdge)
  );

  // both sources run at the same nominal rate, so the counter math is unchanged
  assign selXtal  = stateReg.cfgB[SLEEP_SEL_LSB +: SLEEP_SEL_W] == SLEEP_SEL_XTAL;
  assign slowEdge = selXtal ? pinEdge[1] : pinEdge[0];

  // ***************************************************
  // prescaler
  // ***************************************************
  wut_prescaler uPrescaler (
    .clk      (clk),
    .rst      (rst),
    .enable   (stateReg.running),
    .slowEdge (slowEdge),
    .divSel   (stateReg.cfgA[PRESC_LSB +: PRESC_W]),
    .tick     (tick)
  );

  assign reloadVal = {stateReg.rldHi, stateReg.rldLo};

  // ***************************************************
  // control fields
  // ***************************************************
  assign clkEnable = stateReg.ctrl[CTRL_CLK_EN_BIT];
  assign clearHeld = stateReg.ctrl[CTRL_FLAG_RST_BIT];
  assign armed     = stateReg.cfgB[ARM_BIT];

  // ***************************************************
  // status byte
  // ***************************************************
  function automatic logic [7:0] statusByte(input wut_state_t s);
    logic [7:0] stat;
    stat                    = 8'h00;
    stat[STAT_FLAG_BIT]     = s.flag;
    stat[STAT_CAL_BIT]      = s.calDone;
    stat[STAT_SLEEP_BIT]    = s.sleep;
    stat[STAT_CAL_BUSY_BIT] = s.calBusy;
    statusByte              = stat;
  endfunction

  // ***************************************************
  // register read mux
  // ***************************************************
  function automatic logic [7:0] readMux(input logic [10:0] addr, input wut_state_t s);
    case (addr)
      ADDR_CFG_A:  readMux = s.cfgA;
      ADDR_CFG_B:  readMux = s.cfgB;
      ADDR_CTRL:   readMux = s.ctrl;
      ADDR_RLD_LO: readMux = s.rldLo;
      ADDR_RLD_HI: readMux = s.rldHi;
      ADDR_INT_A:  readMux = s.intA;
      ADDR_INT_B:  readMux = s.intB;
      ADDR_STATUS: readMux = statusByte(s);
      default:     readMux = 8'h00;
    endcase
  endfunction

  // ***************************************************
  // next-state logic
  // ***************************************************
  always_comb begin
    stateNext         = stateReg;
    stateNext.rdValid = 1'b0;
    stateNext.wakeUp  = 1'b0;
    expiry            = 1'b0;
    calStart          = 1'b0;

    // ***************************************************
    // register writes
    // ***************************************************
    // unmapped addresses are ignored
    if (regReq.wr) begin
      case (regReq.addr)
        ADDR_CFG_A:  stateNext.cfgA = regReq.data;
        ADDR_CFG_B:  stateNext.cfgB = regReq.data;
        ADDR_CTRL: begin
          stateNext.ctrl = regReq.data;
          // only a 0 to 1 step starts a run; rewriting 1 does nothing
          calStart = regReq.data[CTRL_CAL_BIT] & ~stateReg.ctrl[CTRL_CAL_BIT];
        end
        ADDR_RLD_LO: stateNext.rldLo = regReq.data;
        ADDR_RLD_HI: stateNext.rldHi = regReq.data;
        ADDR_INT_A:  stateNext.intA = regReq.data;
        ADDR_INT_B:  stateNext.intB = regReq.data;
        default: begin
        end
      endcase
    end

    // ***************************************************
    // register reads
    // ***************************************************
    // answered one cycle later
    if (regReq.rd) begin
      stateNext.rdValid = 1'b1;
      stateNext.rdData  = readMux(regReq.addr, stateReg);
    end

    // ***************************************************
    // down counter
    // ***************************************************
    // reload is taken once per enable and again after zero
    if (!clkEnable) begin
      stateNext.running = 1'b0;
    end else if (!stateReg.running) begin
      stateNext.count   = reloadVal;
      stateNext.running = 1'b1;
    end else if (tick) begin
      if (stateReg.count == 16'h0000) begin
        stateNext.count = reloadVal;
      end else begin
        stateNext.count = stateReg.count - 16'h0001;
        expiry          = stateReg.count == 16'h0001;
      end
    end

    // ***************************************************
    // timeout flag
    // ***************************************************
    // clear field wins over a coinciding expiry while it is held at 1
    if (clearHeld) begin
      stateNext.flag = 1'b0;
    end else if (expiry) begin
      stateNext.flag = 1'b1;
    end

    // ***************************************************
    // interrupt lines
    // ***************************************************
    // each line shows the flag only while its enable bit is set
    stateNext.irqA = stateNext.flag & stateReg.intA[INT_TIMEOUT_BIT];
    stateNext.irqB = stateNext.flag & stateReg.intB[INT_TIMEOUT_BIT];

    // ***************************************************
    // sleep and wake
    // ***************************************************
    // a wake in the same cycle beats a new sleep
    if (stateReg.sleep && armed && expiry) begin
      stateNext.sleep  = 1'b0;
      stateNext.wakeUp = 1'b1;
    end else if (sleepCmd) begin
      stateNext.sleep = 1'b1;
    end

    // ***************************************************
    // rc calibration
    // ***************************************************
    // restarting clears the done flag
    if (calStart) begin
      stateNext.calBusy = 1'b1;
      stateNext.calDone = 1'b0;
      stateNext.calCnt  = CAL_CNT_W'(CAL_TICKS - 1);
    end else if (stateReg.calBusy) begin
      if (stateReg.calCnt == '0) begin
        stateNext.calBusy = 1'b0;
        stateNext.calDone = 1'b1;
      end else begin
        stateNext.calCnt = stateReg.calCnt - CAL_CNT_W'(1);
      end
    end
  end

  // ***************************************************
  // state register
  // ***************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      stateReg         <= '0;
      stateReg.cfgA    <= REG_RESET;
      stateReg.cfgB    <= REG_RESET;
      stateReg.ctrl    <= REG_RESET;
      stateReg.rldLo   <= REG_RESET;
      stateReg.rldHi   <= REG_RESET;
      stateReg.intA    <= REG_RESET;
      stateReg.intB    <= REG_RESET;
      stateReg.count   <= COUNT_RESET;
      stateReg.rdData  <= REG_RESET;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign rdData      = stateReg.rdData;
  assign rdValid     = stateReg.rdValid;
  assign irqLineA    = stateReg.irqA;
  assign irqLineB    = stateReg.irqB;
  assign sleepState  = stateReg.sleep;
  assign wakeUp      = stateReg.wakeUp;
  assign rcCalActive = stateReg.calBusy;

endmodule
`default_nettype wire

// [verif/wut_wake_timer_properties.sv]
// checker: port-level timing of the wake-up timer
`timescale 1ns/1ps
`default_nettype none
module wut_wake_timer_properties
  import wut_pkg::*;
#(
  parameter int CAL_TICKS = CAL_CYCLES
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire wut_regreq_t regReq,
  input wire logic [7:0]  rdData,
  input wire logic        rdValid,
  input wire logic        sleepCmd,
  input wire logic        irqLineA,
  input wire logic        irqLineB,
  input wire logic        sleepState,
  input wire logic        wakeUp,
  input wire logic        rcCalActive
);
  // counts cycles of calibration; a counter, since the length is a parameter
  logic [31:0] calCnt_reg;
  always_ff @(posedge clk) begin
    if (rst || !rcCalActive) calCnt_reg <= '0;
    else calCnt_reg <= calCnt_reg + 32'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence sClearWr;
    regReq.wr && regReq.addr == ADDR_CTRL && regReq.data[CTRL_FLAG_RST_BIT];
  endsequence
  sequence sWakeEnd;
    $past(sleepState) ##1 !wakeUp;
  endsequence
  a_read_answer: assert property (regReq.rd |=> rdValid)
    else $error("read not answered");
  a_no_stray_valid: assert property (!regReq.rd |=> !rdValid)
    else $error("stray read valid");
  a_unmapped_zero: assert property (regReq.rd && (regReq.addr < ADDR_CFG_A
    || regReq.addr > ADDR_STATUS) |=> rdData == REG_RESET) else $error("unmapped not zero");
  a_rd_data_hold: assert property (!regReq.rd |=> $stable(rdData))
    else $error("read data moved");
  a_flag_clear_wins: assert property (sClearWr |-> ##2 !irqLineA && !irqLineB)
    else $error("flag not cleared");
  a_sleep_entry: assert property (sleepCmd |=> sleepState || wakeUp)
    else $error("sleep not entered");
  a_sleep_cause: assert property ($rose(sleepState) |-> $past(sleepCmd))
    else $error("sleep without command");
  a_wake_exit: assert property ($fell(sleepState) |-> wakeUp)
    else $error("sleep left without wake");
  a_wake_pulse: assert property (wakeUp |-> sWakeEnd)
    else $error("wake pulse wrong");
  a_cal_length: assert property ($fell(rcCalActive) |-> calCnt_reg == CAL_TICKS)
    else $error("calibration length wrong");
endmodule
bind wut_wake_timer wut_wake_timer_properties #(.CAL_TICKS(CAL_TICKS)) u_props (
  .clk(clk), .rst(rst), .regReq(regReq), .rdData(rdData), .rdValid(rdValid),
  .sleepCmd(sleepCmd), .irqLineA(irqLineA), .irqLineB(irqLineB),
  .sleepState(sleepState), .wakeUp(wakeUp), .rcCalActive(rcCalActive));
`default_nettype wire

// [verif/wut_host_model.sv]
// host side model: register access, setup order, sleep and calibration
`timescale 1ns/1ps
`default_nettype none
module wut_host_model
  import wut_pkg::*;
(
  input  wire logic       clk,
  output var wut_regreq_t regReq,
  output var logic        sleepCmd,
  input  wire logic [7:0] rdData,
  input  wire logic       rdValid
);
  initial begin
    regReq = '0;
    sleepCmd = 1'b0;
  end
  // released bus shows inverted values so stale data is never mistaken
  task automatic wrReg(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge clk);
    regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask
  task automatic rdReg(input logic [10:0] a, output logic [7:0] d);
    @(posedge clk);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(posedge clk);
    regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'hff};
    #1 d = rdValid ? rdData : 8'hxx;
  endtask
  task automatic setupTimer(input logic [7:0] cfgB, input logic [2:0] code,
                            input logic [15:0] rld, input logic lineB);
    wrReg(ADDR_CTRL, 8'h00);
    wrReg(ADDR_CFG_B, cfgB & 8'h7f);
    wrReg(ADDR_CFG_A, {5'h00, code});
    wrReg(ADDR_RLD_LO, rld[7:0]);
    wrReg(ADDR_RLD_HI, rld[15:8]);
    wrReg(ADDR_CTRL, 8'h01);
    wrReg(ADDR_CTRL, 8'h00);
    wrReg(ADDR_INT_A, {7'h00, !lineB});
    wrReg(ADDR_INT_B, {7'h00, lineB});
    wrReg(ADDR_CFG_B, cfgB);
  endtask
  task automatic enable();
    wrReg(ADDR_CTRL, 8'h04);
  endtask
  task automatic goSleep();
    @(posedge clk);
    sleepCmd <= 1'b1;
    @(posedge clk);
    sleepCmd <= 1'b0;
  endtask
  task automatic calibrate();
    wrReg(ADDR_CTRL, 8'h00);
    wrReg(ADDR_CTRL, 8'h02);
  endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
// testbench: register map, tick division, expiry, sleep exit, calibration
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wut_pkg::*;
  localparam int CAL_T = 20;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        xtalPin = 1'b0;
  logic        rcOscPin = 1'b0;
  logic        useX = 1'b1;
  wut_regreq_t regReq;
  logic        sleepCmd, rdValid, irqLineA, irqLineB, sleepState, wakeUp, rcCalActive;
  logic [7:0]  rdData, v;
  logic [15:0] rld;
  logic        wakeSeen;
  int          err_count = 0;
  int          compares = 0;
  int          cyc = 0;
  int          edges = 0;
  int          xDiv = 0;
  int          rDiv = 0;
  int          divTab[8] = '{1, 4, 8, 16, 128, 1024, 8192, 65536};
  int          expMap[int];
  logic [10:0] regs[6] = '{ADDR_CFG_A, ADDR_CFG_B, ADDR_RLD_LO, ADDR_RLD_HI, ADDR_INT_A,
                           ADDR_INT_B};
  always #2.5 clk = ~clk;
  wut_wake_timer #(.CAL_TICKS(CAL_T)) dut (.clk(clk), .rst(rst), .regReq(regReq),
    .rdData(rdData), .rdValid(rdValid), .rcOscPin(rcOscPin), .xtalPin(xtalPin),
    .sleepCmd(sleepCmd), .irqLineA(irqLineA), .irqLineB(irqLineB),
    .sleepState(sleepState), .wakeUp(wakeUp), .rcCalActive(rcCalActive));
  wut_host_model h (.clk(clk), .regReq(regReq), .sleepCmd(sleepCmd), .rdData(rdData),
    .rdValid(rdValid));
  // slow clocks shortened to 20 and 26 cycles; expectations count their edges
  always @(posedge clk) begin
    cyc <= cyc + 1;
    xDiv <= (xDiv == 9) ? 0 : xDiv + 1;
    rDiv <= (rDiv == 12) ? 0 : rDiv + 1;
    if (xDiv == 9) xtalPin <= ~xtalPin;
    if (rDiv == 12) rcOscPin <= ~rcOscPin;
    if (useX ? (xDiv == 9 && !xtalPin) : (rDiv == 12 && !rcOscPin)) edges <= edges + 1;
    if (cyc == 60000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic rdChk(input logic [10:0] a, input logic [7:0] e);
    logic [7:0] d;
    h.rdReg(a, d);
    chk("register", {24'h0, e}, {24'h0, d});
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hffb2399e));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int a = 'h316; a <= 'h31d; a++) rdChk(a[10:0], REG_RESET);
    $display("test reset values done");
    foreach (regs[i]) begin
      v = 8'($urandom());
      expMap[regs[i]] = v;
      h.wrReg(regs[i], v);
    end
    h.wrReg(11'h320, 8'h5a);
    foreach (regs[i]) rdChk(regs[i], 8'(expMap[regs[i]]));
    rdChk(11'h320, 8'h00);
    $display("test register access done");
    for (int c = 0; c < 6; c++) begin
      rld = (c > 3) ? 16'h0001 : 16'($urandom_range(1, 3));
      if (c == 0) rld = rld | 16'h0100;
      useX = !c[0];
      h.setupTimer({1'(c == 0), useX ? SLEEP_SEL_XTAL : 4'h0, 3'h0}, c[2:0], rld, c[1]);
      while (!(useX ? xtalPin : rcOscPin)) @(posedge clk);
      while (useX ? xtalPin : rcOscPin) @(posedge clk);
      edges = 0;
      h.enable();
      if (c == 0) begin
        h.goSleep();
        #1 chk("sleep state", 32'h1, {31'h0, sleepState});
      end
      wakeSeen = 1'b0;
      while ((c[1] ? irqLineB : irqLineA) !== 1'b1) begin
        @(posedge clk);
        #1 wakeSeen = wakeSeen | wakeUp;
      end
      chk("tick edges", divTab[c] * rld, edges);
      chk("other line", 32'h0, {31'h0, c[1] ? irqLineA : irqLineB});
      if (c == 0) chk("wake", 32'h2, {30'h0, wakeSeen, sleepState});
      h.wrReg(ADDR_CTRL, 8'h01);
      repeat (2) @(posedge clk);
      #1 chk("flag cleared", 32'h0, {30'h0, irqLineA, irqLineB});
      $display("test timer code %0d done", c);
    end
    h.calibrate();
    #1 chk("cal active", 32'h1, {31'h0, rcCalActive});
    rdChk(ADDR_STATUS, 8'h1 << STAT_CAL_BUSY_BIT);
    repeat (CAL_T) @(posedge clk);
    rdChk(ADDR_STATUS, 8'h1 << STAT_CAL_BIT);
    $display("test calibration done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
